// ### vpac_pkg.sv
// Purpose: Constants for the plane access controller
// Assumes: Byte-wide indexed register port, four 8-bit planes
// Notes:   Register indices are graphics controller indices
package vpac_pkg;
  localparam logic [3:0] IDX_SR_DATA    = 4'h0;
  localparam logic [3:0] IDX_SR_ENABLE  = 4'h1;
  localparam logic [3:0] IDX_CMP_COLOR  = 4'h2;
  localparam logic [3:0] IDX_ROP_ROT    = 4'h3;
  localparam logic [3:0] IDX_READ_PLANE = 4'h4;
  localparam logic [3:0] IDX_MODE       = 4'h5;
  localparam logic [3:0] IDX_MAP        = 4'h6;
  localparam logic [3:0] IDX_CMP_MASK   = 4'h7;
  localparam logic [3:0] IDX_BIT_MASK   = 4'h8;
  localparam int MODE_SHIFT256_BIT = 6;
  localparam int MODE_SHIFT_BIT    = 5;
  localparam int MODE_ODDEVEN_BIT  = 4;
  localparam int MODE_READ_BIT     = 3;
  localparam int MODE_WRITE_LSB    = 0;
  localparam int MAP_SEL_LSB       = 2;
  localparam int MAP_CHAIN_BIT     = 1;
  localparam int MAP_GFX_BIT       = 0;
  localparam int ROP_LSB           = 3;
  localparam logic [7:0] MODE_RW_MASK  = 8'h7B;
  localparam logic [7:0] MAP_RW_MASK   = 8'h0F;
  localparam logic [7:0] NIB_RW_MASK   = 8'h0F;
  localparam logic [7:0] ROP_RW_MASK   = 8'h1F;
  localparam logic [7:0] PSEL_RW_MASK  = 8'h03;
  localparam logic [7:0] RESET_VALUE   = 8'h00;
  localparam logic [7:0] BIT_MASK_RESET = 8'hFF;
  localparam int ADDR_W = 20;
  localparam int MEM_W  = 22;
endpackage

// ### vpac_top.sv
// Purpose: Host read/write data paths for a four-plane display memory
// Assumes: One request at a time; plane data is valid in the same cycle as a plane read
// Notes:   Registers reached through an index/data byte port
// Behaviour
// (R1) Mode register bits 6,5,4 enable 256-colour shift, shift mode, odd/even.
// (R2) Read mode 0 returns the byte of the selected read plane.
// (R3) Read mode 1 returns colour compare result, not raw plane data.
// (R4) Write mode 0 uses the normal direct data path.
// (R5) Write mode 1 stores processor latches into all four planes, or into the chained plane pair when chained.
// (R6) Write mode 1 bypasses raster op, rotate, set/reset and bit mask.
// (R7) Map bits 3:2 select the aperture; outside addresses are not claimed.
// (R8) Aperture addresses map into memory offset by the bank base.
// (R9) Chain bit replaces address bit 0 with a high bit; bit 0 picks plane.
// (R10) Chained bit 0 zero selects planes 0/2, one selects planes 1/3.
// (R11) Map bit 0 selects text or graphics display addressing.
// (R12) Compare mask bit one includes its plane; zero always matches.
// (R13) Reserved register bits read back as zero.
// (R14) Write mode 2 replicates host data bits 3:0 across planes 3:0.
// (R15) Write mode 3 uses set/reset colour, ignores enables, mask is rotated data and bit mask.
// (R16) Raster op passes, ANDs, ORs or XORs with latches; rotate right 0..7.
// (R17) Read mode 1 XNORs plane data with compare colour; one means match.
// (R18) Bit mask one writes computed data, zero writes latch bit back.
`timescale 1ns/1ns
`default_nettype none
module vpac_top
  import vpac_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  // Indexed register port
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  input  wire logic                 reg_sel_data_in,
  input  wire logic [7:0]           reg_wdata_in,
  output logic      [7:0]           reg_rdata_out,
  // Host aperture access
  input  wire logic                 host_wr_in,
  input  wire logic                 host_rd_in,
  input  wire logic [vpac_pkg::ADDR_W-1:0] host_addr_in,
  input  wire logic [7:0]           host_wdata_in,
  input  wire logic [vpac_pkg::MEM_W-1:0]  bank_base_in,
  output logic                      host_claim_out,
  output logic                      host_rvalid_out,
  output logic      [7:0]           host_rdata_out,
  // Plane memory
  output logic                      mem_rd_out,
  output logic                      mem_wr_out,
  output logic      [3:0]           mem_plane_en_out,
  output logic      [vpac_pkg::MEM_W-1:0]  mem_addr_out,
  output logic      [31:0]          mem_wdata_out,
  input  wire logic [31:0]          mem_rdata_in,
  // Display-side mode controls
  output logic                      shift256_en_out,
  output logic                      shift_mode_en_out,
  output logic                      odd_even_en_out,
  output logic                      gfx_addr_mode_out,
  output logic                      chargen_latch_en_out
);
  import vpac_pkg::*;

  logic [3:0]  index_reg;
  logic [7:0]  sr_data_reg;
  logic [7:0]  sr_en_reg;
  logic [7:0]  cmp_color_reg;
  logic [7:0]  rop_rot_reg;
  logic [7:0]  read_plane_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  map_reg;
  logic [7:0]  cmp_mask_reg;
  logic [7:0]  bit_mask_reg;
  logic [31:0] latch_reg;
  logic        rd_pend_reg;
  // Host bit 0 of the read in flight; picks the plane of a chained pair on return
  logic        rd_a0_reg;

  function automatic logic [7:0] rotr(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] w;
    w = {d, d} >> n;
    return w[7:0];
  endfunction

  function automatic logic [7:0] rep8(input logic b);
    return {8{b}};
  endfunction

  // Register port: index write, data write/read
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      index_reg      <= 4'h0;
      sr_data_reg    <= RESET_VALUE;
      sr_en_reg      <= RESET_VALUE;
      cmp_color_reg  <= RESET_VALUE;
      rop_rot_reg    <= RESET_VALUE;
      read_plane_reg <= RESET_VALUE;
      mode_reg       <= RESET_VALUE;
      map_reg        <= RESET_VALUE;
      cmp_mask_reg   <= RESET_VALUE;
      bit_mask_reg   <= BIT_MASK_RESET;
    end else if (reg_wr_in && !reg_sel_data_in) begin
      index_reg <= reg_wdata_in[3:0];
    end else if (reg_wr_in) begin
      unique case (index_reg)
        IDX_SR_DATA:    sr_data_reg    <= reg_wdata_in & NIB_RW_MASK; // R13
        IDX_SR_ENABLE:  sr_en_reg      <= reg_wdata_in & NIB_RW_MASK; // R13
        IDX_CMP_COLOR:  cmp_color_reg  <= reg_wdata_in & NIB_RW_MASK; // R13
        IDX_ROP_ROT:    rop_rot_reg    <= reg_wdata_in & ROP_RW_MASK; // R13
        IDX_READ_PLANE: read_plane_reg <= reg_wdata_in & PSEL_RW_MASK; // R13
        IDX_MODE:       mode_reg       <= reg_wdata_in & MODE_RW_MASK; // R1 R13
        IDX_MAP:        map_reg        <= reg_wdata_in & MAP_RW_MASK; // R13
        IDX_CMP_MASK:   cmp_mask_reg   <= reg_wdata_in & NIB_RW_MASK; // R12 R13
        IDX_BIT_MASK:   bit_mask_reg   <= reg_wdata_in;
        default:        ;
      endcase
    end
  end

  // Register read data, reserved bits already stored as zero
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in && !reg_sel_data_in) begin
      reg_rdata_out <= {4'h0, index_reg};
    end else if (reg_rd_in) begin
      unique case (index_reg)
        IDX_SR_DATA:    reg_rdata_out <= sr_data_reg;
        IDX_SR_ENABLE:  reg_rdata_out <= sr_en_reg;
        IDX_CMP_COLOR:  reg_rdata_out <= cmp_color_reg;
        IDX_ROP_ROT:    reg_rdata_out <= rop_rot_reg;
        IDX_READ_PLANE: reg_rdata_out <= read_plane_reg;
        IDX_MODE:       reg_rdata_out <= mode_reg;
        IDX_MAP:        reg_rdata_out <= map_reg;
        IDX_CMP_MASK:   reg_rdata_out <= cmp_mask_reg;
        IDX_BIT_MASK:   reg_rdata_out <= bit_mask_reg;
        default:        reg_rdata_out <= 8'h00; // R13
      endcase
    end
  end

  // Mode outputs for the display side
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift256_en_out      <= 1'b0;
      shift_mode_en_out    <= 1'b0;
      odd_even_en_out      <= 1'b0;
      gfx_addr_mode_out    <= 1'b0;
      chargen_latch_en_out <= 1'b1;
    end else begin
      shift256_en_out      <= mode_reg[MODE_SHIFT256_BIT]; // R1
      shift_mode_en_out    <= mode_reg[MODE_SHIFT_BIT]; // R1
      odd_even_en_out      <= mode_reg[MODE_ODDEVEN_BIT]; // R1
      gfx_addr_mode_out    <= map_reg[MAP_GFX_BIT]; // R11
      chargen_latch_en_out <= !map_reg[MAP_GFX_BIT]; // R11
    end
  end

  // Aperture decode and address mapping
  logic                  in_ap;
  logic [ADDR_W-1:0]     ap_off;
  logic [MEM_W-1:0]      mem_addr;
  logic [3:0]            plane_en;
  logic                  chain;
  always_comb begin
    in_ap  = 1'b0;
    ap_off = '0;
    unique case (map_reg[MAP_SEL_LSB +: 2]) // R7
      2'd0: begin
        in_ap  = host_addr_in[19:17] == 3'b101;
        ap_off = {3'b000, host_addr_in[16:0]};
      end
      2'd1: begin
        in_ap  = host_addr_in[19:16] == 4'hA;
        ap_off = {4'h0, host_addr_in[15:0]};
      end
      2'd2: begin
        in_ap  = host_addr_in[19:15] == 5'b1011_0;
        ap_off = {5'h00, host_addr_in[14:0]};
      end
      2'd3: begin
        in_ap  = host_addr_in[19:15] == 5'b1011_1;
        ap_off = {5'h00, host_addr_in[14:0]};
      end
    endcase
    chain = map_reg[MAP_CHAIN_BIT];
    if (chain) begin
      // Bit 0 becomes plane parity; offset bit 16 takes its place
      ap_off = {1'b0, ap_off[ADDR_W-2:1], ap_off[16]}; // R9
      plane_en = host_addr_in[0] ? 4'b1010 : 4'b0101; // R10
    end else begin
      plane_en = 4'b1111;
    end
    mem_addr = bank_base_in + {{(MEM_W-ADDR_W){1'b0}}, ap_off}; // R8
  end

  // Write data path
  logic [7:0]  rot;
  logic [31:0] wdata;
  logic [7:0]  mask;
  logic [7:0]  src, alu;
  always_comb begin
    rot   = rotr(host_wdata_in, rop_rot_reg[2:0]); // R16
    mask  = bit_mask_reg;
    wdata = latch_reg;
    src   = 8'h00;
    alu   = 8'h00;
    for (int p = 0; p < 4; p++) begin
      unique case (mode_reg[MODE_WRITE_LSB +: 2])
        2'd0: src = sr_en_reg[p] ? rep8(sr_data_reg[p]) : rot; // R4
        2'd1: src = latch_reg[8*p +: 8]; // R5
        2'd2: src = rep8(host_wdata_in[p]); // R14
        2'd3: src = rep8(sr_data_reg[p]); // R15
      endcase
      unique case (rop_rot_reg[ROP_LSB +: 2]) // R16
        2'd0: alu = src;
        2'd1: alu = src & latch_reg[8*p +: 8];
        2'd2: alu = src | latch_reg[8*p +: 8];
        2'd3: alu = src ^ latch_reg[8*p +: 8];
      endcase
      if (mode_reg[MODE_WRITE_LSB +: 2] == 2'd1) begin
        wdata[8*p +: 8] = latch_reg[8*p +: 8]; // R6
      end else begin
        mask = (mode_reg[MODE_WRITE_LSB +: 2] == 2'd3) ? (rot & bit_mask_reg) : bit_mask_reg; // R15
        wdata[8*p +: 8] = (alu & mask) | (latch_reg[8*p +: 8] & ~mask); // R18
      end
    end
  end

  // Memory request and host claim
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_rd_out       <= 1'b0;
      mem_wr_out       <= 1'b0;
      mem_plane_en_out <= 4'h0;
      mem_addr_out     <= '0;
      mem_wdata_out    <= 32'h0000_0000;
      host_claim_out   <= 1'b0;
      rd_pend_reg      <= 1'b0;
      rd_a0_reg        <= 1'b0;
    end else begin
      host_claim_out   <= in_ap && (host_wr_in || host_rd_in); // R7
      mem_rd_out       <= in_ap && host_rd_in;
      mem_wr_out       <= in_ap && host_wr_in;
      mem_plane_en_out <= plane_en;
      mem_addr_out     <= mem_addr;
      mem_wdata_out    <= wdata;
      rd_pend_reg      <= in_ap && host_rd_in;
      rd_a0_reg        <= host_addr_in[0]; // R9
    end
  end

  // Read return: latches load from every plane read
  logic [7:0] rd_byte, cmp;
  logic [1:0] rsel;
  always_comb begin
    rsel = read_plane_reg[1:0];
    if (chain) begin
      // Select bit 0 is ignored when chained, the host's own bit 0 picks odd or even
      rsel[0] = rd_a0_reg; // R9 R10
    end
    rd_byte = mem_rdata_in[8*rsel +: 8]; // R2
    cmp = 8'hFF;
    for (int p = 0; p < 4; p++) begin
      if (cmp_mask_reg[p]) begin
        cmp = cmp & ~(mem_rdata_in[8*p +: 8] ^ rep8(cmp_color_reg[p])); // R12 R17
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_reg       <= 32'h0000_0000;
      host_rvalid_out <= 1'b0;
      host_rdata_out  <= 8'h00;
    end else begin
      host_rvalid_out <= rd_pend_reg;
      if (rd_pend_reg) begin
        latch_reg      <= mem_rdata_in;
        host_rdata_out <= mode_reg[MODE_READ_BIT] ? cmp : rd_byte; // R2 R3
      end
    end
  end
endmodule // vpac_top
`default_nettype wire

// ### vpac_props.sv
// Purpose: Port-level checker for vpac_top
// Assumes: Mode and map shadows follow register port data writes
// Notes:   Shadow reset values equal the design's register reset values
`timescale 1ns/1ns
`default_nettype none
module vpac_props
  import vpac_pkg::*;
(
  // Clock, reset and register port
  input wire logic              sys_clk_in, rst_in, reg_wr_in, reg_sel_data_in,
  input wire logic [7:0]        reg_wdata_in,
  // Host side
  input wire logic              host_wr_in, host_rd_in, host_claim_out, host_rvalid_out,
  input wire logic [ADDR_W-1:0] host_addr_in,
  // Memory and mode outputs
  input wire logic              mem_rd_out, mem_wr_out,
  input wire logic [3:0]        mem_plane_en_out,
  input wire logic              shift256_en_out, shift_mode_en_out, odd_even_en_out,
  input wire logic              gfx_addr_mode_out, chargen_latch_en_out
);
  logic [3:0] idx_reg;
  logic [7:0] mode_reg;
  logic [7:0] map_reg;
  logic       in_ap;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_reg  <= 4'h0;
      mode_reg <= 8'h00;
      map_reg  <= 8'h00;
    end else if (reg_wr_in && !reg_sel_data_in) begin
      idx_reg <= reg_wdata_in[3:0];
    end else if (reg_wr_in && idx_reg == IDX_MODE) begin
      mode_reg <= reg_wdata_in;
    end else if (reg_wr_in && idx_reg == IDX_MAP) begin
      map_reg <= reg_wdata_in;
    end
  end
  always_comb begin
    case (map_reg[3:2])
      2'd0:    in_ap = host_addr_in[19:17] == 3'h5;
      2'd1:    in_ap = host_addr_in[19:16] == 4'hA;
      2'd2:    in_ap = host_addr_in[19:15] == 5'h16;
      default: in_ap = host_addr_in[19:15] == 5'h17;
    endcase
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  AST_CLAIM: assert property ((host_wr_in || host_rd_in) && in_ap |=> host_claim_out)
    else $error("aperture access not claimed");
  AST_NO_CLAIM: assert property ((host_wr_in || host_rd_in) && !in_ap |=> !host_claim_out && !mem_wr_out && !mem_rd_out)
    else $error("access outside aperture claimed");
  AST_READ: assert property (host_rd_in && in_ap |=> mem_rd_out ##1 host_rvalid_out)
    else $error("read answer out of order");
  AST_WR_CAUSE: assert property (mem_wr_out |-> $past(host_wr_in) && host_claim_out)
    else $error("memory write without host write");
  AST_WM1: assert property (host_wr_in && in_ap && mode_reg[1:0] == 2'd1 && !map_reg[1] |=> mem_plane_en_out == 4'hF)
    else $error("write mode 1 misses planes");
  AST_CHAIN: assert property (host_wr_in && in_ap && map_reg[1] |=> mem_plane_en_out == ($past(host_addr_in[0]) ? 4'hA : 4'h5))
    else $error("chained plane pair wrong");
  AST_MODE: assert property (reg_wr_in && reg_sel_data_in && idx_reg == IDX_MODE |-> ##2 {shift256_en_out, shift_mode_en_out, odd_even_en_out} == $past(reg_wdata_in[6:4], 2))
    else $error("mode enables wrong");
  AST_GFX: assert property (reg_wr_in && reg_sel_data_in && idx_reg == IDX_MAP |-> ##2 gfx_addr_mode_out == $past(reg_wdata_in[0], 2) && chargen_latch_en_out != gfx_addr_mode_out)
    else $error("display addressing wrong");
endmodule // vpac_props
bind vpac_top vpac_props vpac_props_i (.sys_clk_in, .rst_in, .reg_wr_in, .reg_sel_data_in, .reg_wdata_in,
  .host_wr_in, .host_rd_in, .host_claim_out, .host_rvalid_out, .host_addr_in, .mem_rd_out, .mem_wr_out,
  .mem_plane_en_out, .shift256_en_out, .shift_mode_en_out, .odd_even_en_out, .gfx_addr_mode_out,
  .chargen_latch_en_out);
`default_nettype wire

// ### vpac_plane_mem.sv
// Purpose: Behavioural four-plane memory behind the controller
// Assumes: Sixteen words, indexed by the low address nibble
// Notes:   Outside read cycles the data bus shows inverted junk
`timescale 1ns/1ns
`default_nettype none
module vpac_plane_mem (
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic [3:0]  en_in,
  input  wire logic [21:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output logic      [31:0] rdata_out
);
  logic [31:0] mem [16];
  logic [31:0] last_reg;
  initial begin
    last_reg = 32'h0000_0000;
    for (int i = 0; i < 16; i++) mem[i] = 32'hC396_5A0F;
  end
  // A late sample would see inverted data, so it cannot match by luck
  assign rdata_out = rd_in ? mem[addr_in[3:0]] : ~last_reg;
  always @(posedge clk_in) begin
    last_reg <= rdata_out;
    for (int p = 0; p < 4; p++) if (wr_in && en_in[p]) mem[addr_in[3:0]][8*p +: 8] <= wdata_in[8*p +: 8];
  end
endmodule // vpac_plane_mem
`default_nettype wire

// ### testbench.sv
// Purpose: Self-checking bench for vpac_top
// Assumes: Plane memory preset to one word, bank base fixed
// Notes:   Ordinary writes run from a row table
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import vpac_pkg::*;
  typedef struct packed {logic [7:0] mode, map, rop; logic [19:0] a; logic [7:0] d;
    logic [3:0] en; logic [21:0] ma; logic [31:0] md;} vpac_row_t;
  localparam logic [31:0] LAT = 32'hC396_5A0F;
  logic        sys_clk_in, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, reg_sel_data_in = 1'b0;
  logic        host_wr_in = 1'b0, host_rd_in = 1'b0, host_claim_out, host_rvalid_out, mem_rd_out, mem_wr_out;
  logic [7:0]  reg_wdata_in = 8'h00, host_wdata_in = 8'h00, reg_rdata_out, host_rdata_out;
  logic [19:0] host_addr_in = 20'h0_0000;
  logic [21:0] bank_base_in = 22'h00_0100, mem_addr_out;
  logic [31:0] mem_rdata_in, mem_wdata_out;
  logic [3:0]  mem_plane_en_out;
  logic        shift256_en_out, shift_mode_en_out, odd_even_en_out, gfx_addr_mode_out, chargen_latch_en_out;
  int          err_count = 0, tests_run = 0, cyc = 0;
  logic [7:0]  cm [3] = '{8'h0F, 8'h01, 8'h00};
  logic [7:0]  ce [3] = '{8'h04, 8'h0F, 8'hFF};
  vpac_row_t   rows [13] = '{
    '{8'h00, 8'h00, 8'h00, 20'hA_0001, 8'h81, 4'hF, 22'h00_0101, 32'h8181_8181},
    '{8'h00, 8'h00, 8'h08, 20'hA_0002, 8'hF0, 4'hF, 22'h00_0102, 32'hC090_5000},
    '{8'h00, 8'h00, 8'h10, 20'hA_0003, 8'h30, 4'hF, 22'h00_0103, 32'hF3B6_7A3F},
    '{8'h00, 8'h00, 8'h18, 20'hA_0004, 8'hFF, 4'hF, 22'h00_0104, 32'h3C69_A5F0},
    '{8'h00, 8'h00, 8'h07, 20'hA_0006, 8'h81, 4'hF, 22'h00_0106, 32'h0303_0303},
    '{8'h01, 8'h00, 8'h18, 20'hA_0007, 8'h55, 4'hF, 22'h00_0107, LAT},
    '{8'h02, 8'h00, 8'h00, 20'hA_0008, 8'h05, 4'hF, 22'h00_0108, 32'h00FF_00FF},
    '{8'h03, 8'h00, 8'h00, 20'hA_0009, 8'hF0, 4'hF, 22'h00_0109, 32'h03F6_FA0F},
    '{8'h00, 8'h04, 8'h00, 20'hB_0000, 8'h00, 4'h0, 22'h00_0000, 32'h0000_0000},
    '{8'h00, 8'h08, 8'h00, 20'hB_7FFE, 8'h00, 4'hF, 22'h00_0000, 32'h0000_0000},
    '{8'h00, 8'h0C, 8'h00, 20'hB_8000, 8'h00, 4'hF, 22'h00_0000, 32'h0000_0000},
    '{8'h00, 8'h02, 8'h00, 20'hA_0000, 8'h11, 4'h5, 22'h00_0100, 32'h1111_1111},
    '{8'h00, 8'h02, 8'h00, 20'hB_0001, 8'h22, 4'hA, 22'h01_0101, 32'h2222_2222}};
  vpac_top vpac_top_i (.sys_clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_sel_data_in, .reg_wdata_in,
    .reg_rdata_out, .host_wr_in, .host_rd_in, .host_addr_in, .host_wdata_in, .bank_base_in, .host_claim_out,
    .host_rvalid_out, .host_rdata_out, .mem_rd_out, .mem_wr_out, .mem_plane_en_out, .mem_addr_out,
    .mem_wdata_out, .mem_rdata_in, .shift256_en_out, .shift_mode_en_out, .odd_even_en_out,
    .gfx_addr_mode_out, .chargen_latch_en_out);
  vpac_plane_mem vpac_plane_mem_i (.clk_in(sys_clk_in), .rd_in(mem_rd_out), .wr_in(mem_wr_out),
    .en_in(mem_plane_en_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] i, input logic [7:0] v);
    @(negedge sys_clk_in);
    reg_wr_in = 1'b1;
    reg_sel_data_in = 1'b0;
    reg_wdata_in = {4'h0, i};
    @(negedge sys_clk_in);
    reg_sel_data_in = 1'b1;
    reg_wdata_in = v;
    @(negedge sys_clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rreg(input logic [3:0] i, input logic [7:0] e);
    @(negedge sys_clk_in);
    reg_wr_in = 1'b1;
    reg_sel_data_in = 1'b0;
    reg_wdata_in = {4'h0, i};
    @(negedge sys_clk_in);
    reg_wr_in = 1'b0;
    reg_sel_data_in = 1'b1;
    reg_rd_in = 1'b1;
    @(negedge sys_clk_in);
    reg_rd_in = 1'b0;
    chk("reg_rdata", e, reg_rdata_out);
  endtask
  task automatic hacc(input logic w, input logic [19:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    host_wr_in = w;
    host_rd_in = !w;
    host_addr_in = a;
    host_wdata_in = d;
    @(negedge sys_clk_in);
    host_wr_in = 1'b0;
    host_rd_in = 1'b0;
  endtask
  task automatic hrd(input logic [7:0] e);
    hacc(1'b0, 20'hA_000F, 8'h00);
    @(negedge sys_clk_in);
    chk("rvalid", 1, host_rvalid_out);
    chk("rdata", e, host_rdata_out);
  endtask
  task automatic do_reset;
    rst_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    rst_in = 1'b0;
    chk("chargen", 1, chargen_latch_en_out);
    rreg(IDX_BIT_MASK, 8'hFF);
  endtask
  task automatic results;
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  initial begin
    do_reset();
    wreg(IDX_MODE, 8'hFF);
    rreg(IDX_MODE, 8'h7B);
    chk("mode_en", 3'b111, {shift256_en_out, shift_mode_en_out, odd_even_en_out});
    wreg(IDX_CMP_MASK, 8'hFF);
    rreg(IDX_CMP_MASK, 8'h0F);
    wreg(IDX_MAP, 8'hF1);
    rreg(IDX_MAP, 8'h01);
    chk("gfx", 2'b10, {gfx_addr_mode_out, chargen_latch_en_out});
    wreg(4'hF, 8'hFF);
    rreg(4'hF, 8'h00);
    wreg(IDX_SR_DATA, 8'h06);
    wreg(IDX_MODE, 8'h00);
    wreg(IDX_MAP, 8'h00);
    hrd(LAT[7:0]);
    foreach (rows[k]) begin
      wreg(IDX_MODE, rows[k].mode);
      wreg(IDX_MAP, rows[k].map);
      wreg(IDX_ROP_ROT, rows[k].rop);
      hacc(1'b1, rows[k].a, rows[k].d);
      chk("claim", rows[k].en != 4'h0, host_claim_out);
      chk("mem_wr", rows[k].en != 4'h0, mem_wr_out);
      if (rows[k].en != 4'h0) chk("plane_en", rows[k].en, mem_plane_en_out);
      if (rows[k].en != 4'h0) chk("wdata", rows[k].md, mem_wdata_out);
      if (rows[k].en != 4'h0 && rows[k].map[3:2] == 2'd0) chk("addr", rows[k].ma, mem_addr_out);
    end
    wreg(IDX_MAP, 8'h00);
    wreg(IDX_MODE, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wreg(IDX_READ_PLANE, 8'(p));
      hrd(LAT[8*p +: 8]);
    end
    wreg(IDX_MODE, 8'h08);
    wreg(IDX_CMP_COLOR, 8'h05);
    for (int j = 0; j < 3; j++) begin
      wreg(IDX_CMP_MASK, cm[j]);
      hrd(ce[j]);
    end
    wreg(IDX_MODE, 8'h00);
    wreg(IDX_ROP_ROT, 8'h00);
    wreg(IDX_BIT_MASK, 8'h0F);
    hacc(1'b1, 20'hA_0003, 8'hFF);
    chk("masked", 32'hCF9F_5F0F, mem_wdata_out);
    wreg(IDX_MAP, 8'h03);
    wreg(IDX_READ_PLANE, 8'h00);
    hacc(1'b0, 20'hA_0001, 8'h00);
    @(negedge sys_clk_in);
    chk("chain_rd", 8'h00, host_rdata_out);
    chk("gfx_set", 2'b10, {gfx_addr_mode_out, chargen_latch_en_out});
    do_reset();
    rreg(IDX_MODE, 8'h00);
    results();
  end
endmodule // testbench
`default_nettype wire
